// ===== design/lcpc_defines.vh
// Register map, field positions, reset values and timing constants
`ifndef LCPC_DEFINES_VH
`define LCPC_DEFINES_VH

`define LCPC_ADDR_CFG        8'h08
`define LCPC_ADDR_CHEN       8'h09
`define LCPC_ADDR_PHASE      8'h0A

`define LCPC_CFG_RESET       8'h1F
`define LCPC_CHEN_RESET      6'h3F
`define LCPC_PHASE_RESET     8'h00

`define LCPC_CFG_FOLLOW_BIT  6
`define LCPC_CFG_ANALOG_BIT  5
`define LCPC_CFG_DRIVE_HI    4
`define LCPC_CFG_DRIVE_LO    3
`define LCPC_CFG_FREQ_BIT    2
`define LCPC_CFG_SHORT_HI    1
`define LCPC_CFG_SHORT_LO    0

`define LCPC_PH_EVEN_BIT     7
`define LCPC_PH_CODE_HI      6
`define LCPC_PH_CODE_LO      0
`define LCPC_PH_DIVISOR      255

`define LCPC_CLK_FREQ_KHZ    200000
`define LCPC_TB_FREQ_KHZ     12800

`endif

// ===== design/lcpc_top.v
// Per-channel enable, fault shutdown, configuration and phase staggering of LED strings
//
// Operation
// - Channel enable bit i drives channel i
// - Enable write sets exactly the written channels
// - Readback shows one only for enabled healthy channels
// - Disable then enable clears fault, retries channel
// - Enable register resets with all six set
// - Follow mode drives sources from dimming input
// - Analog mode keeps sources continuously on
// - Bits 4:3 select boost gate drive strength
// - Bit 2 selects boost switching frequency
// - Bits 1:0 select short-circuit threshold
// - Even mode spaces channels period over N
// - Manual delay is code times period/255
// - Follow mode delay is code timebase ticks
// - Phase register resets to zero
// - Configuration register resets to 0x1F
`include "lcpc_defines.vh"

module lcpc_top #(
  parameter CNT_W = 20
) (
  input  wire             sys_clk,
  input  wire             reset_n,
  input  wire [7:0]       reg_addr,
  input  wire             reg_wr,
  input  wire             reg_rd,
  input  wire [7:0]       reg_wdata,
  output reg  [7:0]       reg_rdata,
  output reg              reg_rvalid,
  input  wire             dimming_input_pin,
  input  wire [5:0]       ch_fault,
  output reg  [5:0]       ch_drive,
  output wire             input_follow_mode,
  output wire             duty_to_analog_mode,
  output wire [1:0]       boost_gate_drive_strength,
  output wire             boost_freq_select,
  output wire [1:0]       short_thresh_select
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg  [7:0]       cfg_q;
  reg  [5:0]       chen_q;
  reg  [7:0]       phase_q;
  reg  [5:0]       fault_q;
  wire [5:0]       healthy;
  wire             wr_chen;

  assign wr_chen = reg_wr && (reg_addr == `LCPC_ADDR_CHEN);
  assign healthy = chen_q & ~fault_q;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q   <= `LCPC_CFG_RESET;
      chen_q  <= `LCPC_CHEN_RESET;
      phase_q <= `LCPC_PHASE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `LCPC_ADDR_CFG) begin
        cfg_q <= reg_wdata;
      end
      if (wr_chen) begin
        chen_q <= reg_wdata[5:0];
      end
      if (reg_addr == `LCPC_ADDR_PHASE) begin
        phase_q <= reg_wdata;
      end
    end
  end

  // Fault latch per channel; a new fault wins over a disabling write
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_fault
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          fault_q[gi] <= 1'b0;
        end else if (ch_fault[gi] && chen_q[gi]) begin
          fault_q[gi] <= 1'b1;
        end else if (wr_chen && !reg_wdata[gi]) begin
          fault_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `LCPC_ADDR_CFG:   reg_rdata <= cfg_q;
          `LCPC_ADDR_CHEN:  reg_rdata <= {2'b00, healthy};
          `LCPC_ADDR_PHASE: reg_rdata <= phase_q;
          default:          reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  assign input_follow_mode         = cfg_q[`LCPC_CFG_FOLLOW_BIT];
  assign duty_to_analog_mode       = cfg_q[`LCPC_CFG_ANALOG_BIT];
  assign boost_gate_drive_strength = cfg_q[`LCPC_CFG_DRIVE_HI:`LCPC_CFG_DRIVE_LO];
  assign boost_freq_select         = cfg_q[`LCPC_CFG_FREQ_BIT];
  assign short_thresh_select       = cfg_q[`LCPC_CFG_SHORT_HI:`LCPC_CFG_SHORT_LO];

  // ****************************************************************
  // Dimming input period and high-time measurement
  // ****************************************************************
  localparam [CNT_W-1:0] T_MAX = {CNT_W{1'b1}};
  reg  [CNT_W-1:0] t_q;
  reg  [CNT_W-1:0] period_q;
  reg  [CNT_W-1:0] high_q;
  reg              din_q;
  reg              dprev_q;
  wire             rise;
  wire             fall;
  wire             stale;

  assign rise  = din_q && !dprev_q;
  assign fall  = !din_q && dprev_q;
  // Without edges there is no period to stagger against, so channels follow the level
  assign stale = (t_q == T_MAX) || (period_q == {CNT_W{1'b0}});

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      din_q    <= 1'b0;
      dprev_q  <= 1'b0;
      t_q      <= T_MAX;
      period_q <= {CNT_W{1'b0}};
      high_q   <= {CNT_W{1'b0}};
    end else begin
      din_q   <= dimming_input_pin;
      dprev_q <= din_q;
      if (rise) begin
        t_q <= {CNT_W{1'b0}};
        if (t_q != T_MAX) begin
          period_q <= t_q + 1'b1;
        end
      end else if (t_q != T_MAX) begin
        t_q <= t_q + 1'b1;
      end
      if (fall && t_q != T_MAX) begin
        high_q <= t_q + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Phase offsets and channel drive
  // ****************************************************************
  wire [2:0]  n_en;
  wire [6:0]  code;
  wire [31:0] period_w;
  wire [31:0] man_step;

  assign n_en = {2'b00, healthy[0]} + {2'b00, healthy[1]} + {2'b00, healthy[2]}
              + {2'b00, healthy[3]} + {2'b00, healthy[4]} + {2'b00, healthy[5]};
  assign code = phase_q[`LCPC_PH_CODE_HI:`LCPC_PH_CODE_LO];
  assign period_w = {{(32-CNT_W){1'b0}}, period_q};
  assign man_step = ({25'd0, code} * period_w) / `LCPC_PH_DIVISOR;

  // Offset of the k-th enabled channel; limited to one period by the host
  function [31:0] lcpc_offset;
    input [2:0]  k;
    input [2:0]  n;
    input        even;
    input        follow;
    input [31:0] per;
    input [31:0] step;
    input [6:0]  cd;
    reg   [31:0] kp;
    begin
      kp = per * {29'd0, k};
      if (follow) begin
        lcpc_offset = ({25'd0, cd} * {29'd0, k} * `LCPC_CLK_FREQ_KHZ)
                      / `LCPC_TB_FREQ_KHZ;
      end else if (even) begin
        case (n)
          3'd2:    lcpc_offset = kp / 2;
          3'd3:    lcpc_offset = kp / 3;
          3'd4:    lcpc_offset = kp / 4;
          3'd5:    lcpc_offset = kp / 5;
          3'd6:    lcpc_offset = kp / 6;
          default: lcpc_offset = 32'd0;
        endcase
      end else begin
        lcpc_offset = step * {29'd0, k};
      end
    end
  endfunction

  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_ch
      wire [2:0]  rank;
      wire [31:0] off;
      wire [31:0] tw;
      wire [31:0] pos;
      wire        win;
      wire        drive_d;
      if (gi == 0) begin : g_r0
        assign rank = 3'd0;
      end else begin : g_rn
        assign rank = g_ch[gi-1].rank + {2'b00, healthy[gi-1]};
      end
      assign off = lcpc_offset(rank, n_en, phase_q[`LCPC_PH_EVEN_BIT],
                               input_follow_mode, period_w, man_step, code);
      // Window starts in the cycle the rise is seen, level with a follow-mode first channel
      assign tw  = rise ? 32'h0 : ({{(32-CNT_W){1'b0}}, t_q} + 32'h1);
      assign pos = (tw >= off) ? (tw - off) : (tw + period_w - off);
      assign win = pos < {{(32-CNT_W){1'b0}}, high_q};
      // The first enabled channel in follow mode tracks the pin with no reconstruction
      assign drive_d = duty_to_analog_mode ? 1'b1 :
                       (stale || (input_follow_mode && rank == 3'd0)) ? din_q :
                       win;
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          ch_drive[gi] <= 1'b0;
        end else begin
          ch_drive[gi] <= healthy[gi] && drive_d;
        end
      end
    end
  endgenerate

endmodule // lcpc_top

// ===== tb/lcpc_checker.sv
// Port assertions for the LED channel control block
module lcpc_checker (
  input wire       sys_clk,
  input wire       reset_n,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       reg_rvalid,
  input wire       dimming_input_pin,
  input wire [5:0] ch_fault,
  input wire [5:0] ch_drive,
  input wire       input_follow_mode,
  input wire       duty_to_analog_mode,
  input wire [1:0] boost_gate_drive_strength,
  input wire       boost_freq_select,
  input wire [1:0] short_thresh_select
);
  wire [6:0] cfg = {input_follow_mode, duty_to_analog_mode, boost_gate_drive_strength,
                    boost_freq_select, short_thresh_select};
  wire [6:0] wd  = reg_wdata[6:0];
  wire [5:0] we  = reg_wdata[5:0];
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved");
  chk_cfg_fields: assert property (reg_wr && reg_addr == 8'h08 |=> cfg == $past(wd))
    else $error("config fields wrong");
  chk_cfg_reset: assert property ($rose(reset_n) |-> cfg == 7'h1F)
    else $error("config reset wrong");
  chk_en_reserved: assert property (reg_rd && reg_addr == 8'h09 |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved enable bits set");
  chk_unmapped_read: assert property (reg_rd && reg_addr > 8'h0A |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Only quiet cycles count, a later write may legally re-enable
  chk_disable_off: assert property ((reg_wr && reg_addr == 8'h09) ##1 !reg_wr
    |=> (ch_drive & ~$past(we, 2)) == 6'h00)
    else $error("disabled channel drives");
  chk_fault_off: assert property ((|ch_fault) && !reg_wr
    |=> ##1 (ch_drive & $past(ch_fault, 2)) == 6'h00)
    else $error("faulted channel drives");
endmodule // lcpc_checker

bind lcpc_top lcpc_checker i_chk (.*);

// ===== tb/lcpc_host.sv
// Register host model on the strobe bus
module lcpc_host (
  input  wire        sys_clk,
  input  wire  [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Idle lines are inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule // lcpc_host

// ===== tb/testbench.sv
// Self-checking bench for the LED channel control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 40;
  logic       sys_clk, reset_n, dimming_input_pin, pwm, lvl;
  logic [5:0] ch_fault;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, reg_rvalid, input_follow_mode, duty_to_analog_mode;
  wire        boost_freq_select;
  wire  [1:0] boost_gate_drive_strength, short_thresh_select;
  wire  [5:0] ch_drive;
  int         failures, check_count, seed, i, n, c;
  logic [7:0] v, d;
  lcpc_top #(.CNT_W(12)) i_dut (.*);
  lcpc_host i_host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    c <= (c + 1) % P;
    dimming_input_pin <= pwm ? c < P / 2 : lvl;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk(d, e);
  endtask
  // Two channels enabled, so even spacing is half a period
  function int offs(input int m, input int code);
    offs = m == 2 ? code * 200000 / 12800 : m ? P / 2 : code * P / 255;
  endfunction
  task wt(input int ch, input logic b);
    n = 0;
    while (ch_drive[ch] !== b && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 300) begin
      failures++;
      print_verdict();
    end
  endtask
  task lag(input int e);
    wt(0, 0);
    wt(0, 1);
    wt(2, 1);
    chk(n[7:0], e[7:0]);
  endtask
  task print_verdict();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    seed = 47538;
    reset_n = 1'b0;
    ch_fault = 6'h00;
    {pwm, lvl, c, failures, check_count} = 0;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    rchk(8'h08, 8'h1F);
    rchk(8'h09, 8'h3F);
    rchk(8'h0A, 8'h00);
    rchk(8'h0B, 8'h00);
    $display("reset done");
    for (i = 0; i < 12; i++) begin
      v = $random(seed) & 8'hE4 | (i % 4) * 9;
      i_host.wr(8'h08, v);
      rchk(8'h08, v);
      v = $random(seed);
      i_host.wr(8'h0A, v);
      rchk(8'h0A, v);
      v = $random(seed);
      i_host.wr(8'h09, v);
      rchk(8'h09, v & 8'h3F);
    end
    $display("registers done");
    i_host.wr(8'h08, 8'h20);
    i_host.wr(8'h09, 8'h3F);
    ch_fault = 6'h04;
    @(negedge sys_clk);
    ch_fault = 6'h00;
    rchk(8'h09, 8'h3B);
    chk({2'b00, ch_drive}, 8'h3B);
    i_host.wr(8'h09, 8'h3B);
    i_host.wr(8'h09, 8'h3F);
    rchk(8'h09, 8'h3F);
    chk({2'b00, ch_drive}, 8'h3F);
    $display("fault done");
    i_host.wr(8'h08, 8'h40);
    i_host.wr(8'h0A, 8'h00);
    i_host.wr(8'h09, 8'h05);
    for (i = 0; i < 4; i++) begin
      lvl = ~lvl;
      repeat (3) @(negedge sys_clk);
      chk({7'h00, ch_drive[0]}, {7'h00, lvl});
    end
    pwm = 1'b1;
    i_host.wr(8'h0A, 8'h01);
    repeat (100) @(negedge sys_clk);
    lag(offs(2, 1));
    $display("follow done");
    i_host.wr(8'h08, 8'h1F);
    for (i = 0; i < 2; i++) begin
      i_host.wr(8'h0A, i ? 8'h40 : 8'h80);
      repeat (100) @(negedge sys_clk);
      lag(offs(i ? 0 : 1, 64));
    end
    $display("phase done");
    print_verdict();
  end
endmodule // testbench
